// ---- hdl/pesr_top.sv ----
// Purpose: builds sampling records on counter overflow, writes them out
// Assumes: core holds snapshot inputs stable while o_capture_busy is high
// Notes: registers on avalon-mm, one interrupt level output
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pesr_top
  import pesr_pkg::*;
#(
  parameter int GPR_COUNT = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  // avalon-mm slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // counters and retirement snapshot
  input wire logic [NUM_COUNTERS-1:0] i_overflow,
  input wire logic i_precise_distribution_retired_overflow,
  input wire logic [63:0] i_flags,
  input wire logic [63:0] i_ip_after1,
  input wire logic [63:0] i_ip_after2,
  input wire logic i_fused,
  input wire logic [GPR_COUNT*64-1:0] i_gpr,
  input wire logic [63:0] i_global_status,
  input wire logic i_addr_valid,
  input wire logic [63:0] i_data_addr,
  input wire logic i_is_store,
  input wire logic i_l1_hit,
  input wire logic i_src_valid,
  input wire logic [63:0] i_data_src,
  input wire logic i_lat_valid,
  input wire logic [63:0] i_load_latency,
  input wire logic [63:0] i_trigger_ip,
  input wire logic i_tx_valid,
  input wire logic [63:0] i_tx_abort,
  output logic o_capture_busy,
  // record write port
  output logic o_mem_valid,
  output logic [63:0] o_mem_addr,
  output logic [63:0] o_mem_data,
  input wire logic i_mem_ready,
  output logic o_record_done,
  output logic o_irq
);
  localparam logic [4:0] LAST_SLOT = 5'(REC_SLOTS - 1);

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // engine state
  pesr_state_t state_q, state_d;
  logic [4:0] widx_q, widx_d;
  logic [4:0] ridx_q, ridx_d;
  logic [63:0] rec_ptr_q, rec_ptr_d;
  logic [31:0] count_q, count_d;
  logic mem_valid_q, mem_valid_d;
  logic [63:0] mem_addr_q, mem_addr_d;
  logic [63:0] mem_data_q, mem_data_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  // register state
  logic [31:0] ctrl_q, ctrl_d;
  logic [ST_BITS-1:0] stat_q, stat_d;
  logic [ST_BITS-1:0] mask_q, mask_d;
  logic [63:0] base_q, base_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  // shared combinational
  logic [SAMPLING_COUNTERS-1:0] fire_vec;
  logic fire, ev_done, ev_drop, base_wr, slot_we, slot_re;
  logic [63:0] slot_wdata, slot_rdata;
  logic [7:0] wbyte;
  logic bus_req, bus_fin;
  logic [31:0] mask_wr;

  assign bus_req = i_read | i_write;
  assign bus_fin = bus_req & ~wait_q;
  assign wbyte = {widx_q, 3'b000};

  // trigger selection
  always_comb begin
    fire_vec = i_overflow[SAMPLING_COUNTERS-1:0] &
               ctrl_q[SAMPLING_COUNTERS-1:0];
    if (ctrl_q[CTRL_PRECISE_DISTRIBUTION_RETIRED_BIT]) begin
      fire_vec[PRECISE_DISTRIBUTION_RETIRED_COUNTER] = i_precise_distribution_retired_overflow &
                               ctrl_q[PRECISE_DISTRIBUTION_RETIRED_COUNTER];
    end
    fire = |fire_vec;
  end

  // slot contents, same layout in every mode
  always_comb begin
    slot_wdata = 64'h0000_0000_0000_0000;
    if (wbyte == OFF_FLAGS) begin
      slot_wdata = i_flags;
    end else if (wbyte == OFF_NEXT_IP) begin
      slot_wdata = i_fused ? i_ip_after2 : i_ip_after1;
    end else if (wbyte >= OFF_GPR_FIRST && wbyte <= OFF_GPR_LAST) begin
      slot_wdata = i_gpr[(32'(widx_q) - 2) * 64 +: 64];
    end else if (wbyte == OFF_GLOBAL_STATUS) begin
      slot_wdata = i_global_status;
    end else if (wbyte == OFF_DATA_ADDR) begin
      if (i_addr_valid) begin
        slot_wdata = i_data_addr;
      end
    end else if (wbyte == OFF_DATA_SRC) begin
      if (i_is_store) begin
        slot_wdata = {63'h0, i_l1_hit};
      end else if (i_src_valid) begin
        slot_wdata = i_data_src;
      end
    end else if (wbyte == OFF_LATENCY) begin
      if (i_lat_valid && !i_is_store) begin
        slot_wdata = i_load_latency;
      end
    end else if (wbyte == OFF_TRIGGER_IP) begin
      slot_wdata = i_trigger_ip;
    end else if (wbyte == OFF_TX_ABORT) begin
      if (i_tx_valid) begin
        slot_wdata = i_tx_abort;
      end
    end
  end

  pesr_slot_mem #(
    .WIDTH(64),
    .DEPTH(REC_SLOTS),
    .AW(5)
  ) u_mem (
    .i_clock(i_clock),
    .i_we(slot_we),
    .i_waddr(widx_q),
    .i_wdata(slot_wdata),
    .i_re(slot_re),
    .i_raddr(ridx_q),
    .o_rdata(slot_rdata)
  );

  // record engine
  always_comb begin
    state_d = state_q;
    widx_d = widx_q;
    ridx_d = ridx_q;
    rec_ptr_d = rec_ptr_q;
    count_d = count_q;
    mem_valid_d = mem_valid_q;
    mem_addr_d = mem_addr_q;
    mem_data_d = mem_data_q;
    done_d = 1'b0;
    ev_done = 1'b0;
    ev_drop = 1'b0;
    slot_we = 1'b0;
    slot_re = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (fire) begin
          state_d = ST_CAPTURE;
          widx_d = 5'h00;
        end
      end
      ST_CAPTURE: begin
        slot_we = 1'b1;
        if (widx_q == LAST_SLOT) begin
          state_d = ST_FETCH;
          ridx_d = 5'h00;
        end else begin
          widx_d = widx_q + 5'h01;
        end
      end
      ST_FETCH: begin
        slot_re = 1'b1;
        state_d = ST_PRESENT;
      end
      ST_PRESENT: begin
        mem_data_d = slot_rdata;
        mem_addr_d = rec_ptr_q + {56'h0, ridx_q, 3'b000};
        mem_valid_d = 1'b1;
        state_d = ST_SEND;
      end
      ST_SEND: begin
        if (i_mem_ready) begin
          mem_valid_d = 1'b0;
          if (ridx_q == LAST_SLOT) begin
            state_d = ST_DONE;
          end else begin
            ridx_d = ridx_q + 5'h01;
            state_d = ST_FETCH;
          end
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        ev_done = 1'b1;
        count_d = count_q + 32'h0000_0001;
        rec_ptr_d = rec_ptr_q + REC_BYTES;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (fire && state_q != ST_IDLE) begin
      ev_drop = 1'b1;
    end
    if (base_wr) begin
      rec_ptr_d = base_d;
      count_d = 32'h0000_0000;
    end
    busy_d = (state_d == ST_CAPTURE);
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      widx_q <= 5'h00;
      ridx_q <= 5'h00;
      rec_ptr_q <= BASE_RST;
      count_q <= 32'h0000_0000;
      mem_valid_q <= 1'b0;
      mem_addr_q <= 64'h0000_0000_0000_0000;
      mem_data_q <= 64'h0000_0000_0000_0000;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      widx_q <= widx_d;
      ridx_q <= ridx_d;
      rec_ptr_q <= rec_ptr_d;
      count_q <= count_d;
      mem_valid_q <= mem_valid_d;
      mem_addr_q <= mem_addr_d;
      mem_data_q <= mem_data_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // register bus, one wait cycle per access
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    base_d = base_q;
    stat_d = stat_q;
    rdata_d = rdata_q;
    base_wr = 1'b0;
    wait_d = ~(bus_req & wait_q);
    mask_wr = merge_be({30'h0, mask_q}, i_writedata, i_byteenable);
    if (bus_req && wait_q) begin
      rdata_d = 32'h0000_0000;
      if (i_read) begin
        unique case (i_address)
          REG_CTRL: rdata_d = ctrl_q;
          REG_STATUS: rdata_d = {30'h0, stat_q};
          REG_MASK: rdata_d = {30'h0, mask_q};
          REG_BASE_LO: rdata_d = base_q[31:0];
          REG_BASE_HI: rdata_d = base_q[63:32];
          REG_COUNT: rdata_d = count_q;
          REG_CAP: rdata_d = CAP_VALUE;
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
    // clear only the bits that the read returned
    if (bus_fin && i_read && i_address == REG_STATUS) begin
      stat_d = stat_q & ~rdata_q[ST_BITS-1:0];
    end
    if (bus_fin && i_write) begin
      unique case (i_address)
        REG_CTRL: begin
          ctrl_d = merge_be(ctrl_q, i_writedata, i_byteenable);
          ctrl_d[31:CTRL_PRECISE_DISTRIBUTION_RETIRED_BIT+1] = '0;
          ctrl_d[CTRL_PRECISE_DISTRIBUTION_RETIRED_BIT-1:SAMPLING_COUNTERS] = '0;
        end
        REG_MASK: begin
          mask_d = mask_wr[ST_BITS-1:0];
        end
        REG_BASE_LO: begin
          base_d[31:0] = merge_be(base_q[31:0], i_writedata, i_byteenable);
          base_wr = 1'b1;
        end
        REG_BASE_HI: begin
          base_d[63:32] = merge_be(base_q[63:32], i_writedata,
                                   i_byteenable);
          base_wr = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // set wins over read-clear
    if (ev_done) begin
      stat_d[ST_DONE_BIT] = 1'b1;
    end
    if (ev_drop) begin
      stat_d[ST_DROP_BIT] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
      base_q <= BASE_RST;
      stat_q <= '0;
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      base_q <= base_d;
      stat_q <= stat_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      irq_q <= irq_d;
    end
  end

  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_capture_busy = busy_q;
  assign o_mem_valid = mem_valid_q;
  assign o_mem_addr = mem_addr_q;
  assign o_mem_data = mem_data_q;
  assign o_record_done = done_q;
  assign o_irq = irq_q;

  // checks
  a_high_ctr_silent: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == ST_IDLE && i_overflow[3:0] == 4'h0 && !i_precise_distribution_retired_overflow)
    |=> state_q == ST_IDLE) else $error("counter 4-7 started a record");
  a_precise_distribution_retired_only_one: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == ST_IDLE && ctrl_q[CTRL_PRECISE_DISTRIBUTION_RETIRED_BIT] && !i_precise_distribution_retired_overflow &&
     i_overflow[3:0] == 4'h2) |=> state_q == ST_IDLE)
    else $error("plain overflow used in precise_distribution_retired mode");
  a_cap_bit_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_read && !o_waitrequest && i_address == REG_CAP)
    |-> o_readdata[CAP_WIDE_BIT]) else $error("capability bit clear");
  a_flags_slot: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (slot_we && widx_q == 5'h00) |-> slot_wdata == i_flags)
    else $error("flags slot wrong");
  a_store_status: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (slot_we && wbyte == OFF_DATA_SRC && i_is_store)
    |-> slot_wdata == {63'h0, i_l1_hit}) else $error("store status wrong");
  a_trigger_ip: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (slot_we && widx_q == 5'd22) |-> slot_wdata == i_trigger_ip)
    else $error("trigger ip slot wrong");
  a_ip_skid: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (slot_we && widx_q == 5'h01) |->
    slot_wdata == (i_fused ? i_ip_after2 : i_ip_after1))
    else $error("next ip skid wrong");
  a_addr_zeroed: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (slot_we && wbyte == OFF_DATA_ADDR && !i_addr_valid)
    |-> slot_wdata == 64'h0000_0000_0000_0000)
    else $error("stale data address");
  a_capture_first: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (state_q == ST_IDLE && fire) |=> o_capture_busy ##24 state_q == ST_FETCH)
    else $error("capture did not precede write");
  a_done_after_last: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_mem_valid && i_mem_ready && ridx_q == LAST_SLOT) |=> ##1 o_record_done)
    else $error("completion not after last word");
endmodule
`default_nettype wire

// ---- hdl/pesr_pkg.sv ----
// Purpose: shared constants of the precise event sampling record writer
// Assumes: 64-bit record slots, 32-bit register bus
// Notes: byte offsets are record-relative or register-relative
package pesr_pkg;
  // record layout, byte offsets of 8-byte slots
  localparam int REC_SLOTS = 24;
  localparam int SLOT_BYTES = 8;
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_NEXT_IP = 8'h08;
  localparam logic [7:0] OFF_GPR_FIRST = 8'h10;
  localparam logic [7:0] OFF_GPR_LAST = 8'h88;
  localparam logic [7:0] OFF_GLOBAL_STATUS = 8'h90;
  localparam logic [7:0] OFF_DATA_ADDR = 8'h98;
  localparam logic [7:0] OFF_DATA_SRC = 8'hA0;
  localparam logic [7:0] OFF_LATENCY = 8'hA8;
  localparam logic [7:0] OFF_TRIGGER_IP = 8'hB0;
  localparam logic [7:0] OFF_TX_ABORT = 8'hB8;
  localparam logic [63:0] REC_BYTES = 64'h0000_0000_0000_00C0;
  // counters
  localparam int NUM_COUNTERS = 8;
  localparam int SAMPLING_COUNTERS = 4;
  localparam int PRECISE_DISTRIBUTION_RETIRED_COUNTER = 1;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_BASE_LO = 8'h0C;
  localparam logic [7:0] REG_BASE_HI = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  localparam logic [7:0] REG_CAP = 8'h18;
  // fields
  localparam int CTRL_PRECISE_DISTRIBUTION_RETIRED_BIT = 8;
  localparam int CAP_WIDE_BIT = 2;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_DROP_BIT = 1;
  localparam int ST_BITS = 2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [63:0] BASE_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] CAP_VALUE = 32'h0000_0004;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CAPTURE = 3'b001,
    ST_FETCH = 3'b010,
    ST_PRESENT = 3'b011,
    ST_SEND = 3'b100,
    ST_DONE = 3'b101
  } pesr_state_t;
endpackage

// ---- hdl/pesr_slot_mem.sv ----
// Purpose: staging memory for one sampling record
// Assumes: one write port, one read port, registered read data
// Notes: read data valid the cycle after the read enable
`timescale 1ns/1ps
`default_nettype none
module pesr_slot_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 24,
  parameter int AW = 5
) (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    if (i_re) begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule
`default_nettype wire

// ---- tb/pesr_mem_model.sv ----
// Purpose: memory that takes in sampling record words
// Assumes: a word is taken at an edge with valid and ready high
// Notes: slow mode takes one word every four cycles
`timescale 1ns/1ps
`default_nettype none
module pesr_mem_model (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [63:0] i_addr,
  input wire logic [63:0] i_data,
  output logic o_ready,
  output logic [31:0] o_count,
  output logic [63:0] o_last
);
  logic [63:0] word [0:127];
  logic [1:0] gap_q;
  assign o_ready = !i_slow || gap_q == 2'h3;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_q <= 2'h0;
      o_count <= 32'h0000_0000;
      o_last <= 64'h0000_0000_0000_0000;
    end else begin
      gap_q <= gap_q + 2'h1;
      if (i_valid && o_ready) begin
        word[i_addr[9:3]] <= i_data;
        o_count <= o_count + 32'h0000_0001;
        o_last <= i_addr;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: bench for the sampling record writer
// Assumes: bus answer comes one cycle after the request
// Notes: record words are checked in the memory model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pesr_pkg::*;
  logic i_clock = 0, i_rstn = 0, i_read = 0, i_write = 0, i_slow = 0;
  logic [7:0] i_address = '0, i_overflow = '0;
  logic [31:0] i_writedata = '0, o_readdata, rd;
  logic [3:0] i_byteenable = '0;
  logic i_precise_distribution_retired_overflow = 0, i_fused = 0, i_is_store = 0, i_l1_hit = 0;
  logic i_addr_valid = 0, i_src_valid = 0, i_lat_valid = 0;
  logic i_tx_valid = 0, o_waitrequest, o_capture_busy, o_mem_valid;
  logic i_mem_ready, o_record_done, o_irq;
  logic [63:0] v = '0, o_mem_addr, o_mem_data;
  logic [1023:0] i_gpr;
  wire logic [63:0] i_flags = v;
  wire logic [63:0] i_ip_after1 = v | 64'd1;
  wire logic [63:0] i_ip_after2 = v | 64'd2;
  wire logic [63:0] i_global_status = v | 64'd40;
  wire logic [63:0] i_data_addr = v | 64'd41;
  wire logic [63:0] i_data_src = v | 64'd42;
  wire logic [63:0] i_load_latency = v | 64'd43;
  wire logic [63:0] i_trigger_ip = v | 64'd44;
  wire logic [63:0] i_tx_abort = v | 64'd45;
  wire logic [31:0] words;
  wire logic [63:0] last;
  int failures = 0, n_checks = 0, cycles = 0;
  always #5 i_clock = ~i_clock;
  always_comb
    for (int n = 0; n < 16; n++) i_gpr[n*64+:64] = v | 64'(n + 16);
  pesr_top pesr_top_i (.i_clock, .i_rstn, .i_address, .i_read,
    .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
    .i_overflow, .i_precise_distribution_retired_overflow, .i_flags, .i_ip_after1, .i_ip_after2,
    .i_fused, .i_gpr, .i_global_status, .i_addr_valid, .i_data_addr,
    .i_is_store, .i_l1_hit, .i_src_valid, .i_data_src, .i_lat_valid,
    .i_load_latency, .i_trigger_ip, .i_tx_valid, .i_tx_abort,
    .o_capture_busy, .o_mem_valid, .o_mem_addr, .o_mem_data,
    .i_mem_ready, .o_record_done, .o_irq);
  pesr_mem_model pesr_mem_model_i (.i_clock, .i_rstn, .i_slow,
    .i_valid(o_mem_valid), .i_addr(o_mem_addr), .i_data(o_mem_data),
    .o_ready(i_mem_ready), .o_count(words), .o_last(last));
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input string s, input logic [63:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge i_clock);
    i_read <= !w;
    i_write <= w;
    i_address <= a;
    i_writedata <= wd;
    i_byteenable <= 4'hF;
    do begin
      @(posedge i_clock);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 0;
    i_write <= 0;
  endtask
  task automatic rdc(input string s, input logic [7:0] a,
                     input logic [31:0] e);
    bus(0, a, 32'h0000_0000);
    chk(s, 64'(e), 64'(rd));
  endtask
  task automatic fire(input logic [7:0] ov, input logic pd);
    @(posedge i_clock);
    i_overflow <= ov;
    i_precise_distribution_retired_overflow <= pd;
    @(posedge i_clock);
    i_overflow <= '0;
    i_precise_distribution_retired_overflow <= 0;
    @(negedge i_clock);
  endtask
  task automatic snap(input logic [15:0] s, input logic [6:0] f);
    @(posedge i_clock);
    v <= {s, 48'h0000_0000_0000};
    {i_is_store, i_fused, i_l1_hit, i_addr_valid} <= f[6:3];
    {i_src_valid, i_lat_valid, i_tx_valid} <= f[2:0];
  endtask
  function automatic logic [63:0] ex(input int k);
    case (k)
      0: return v;
      1: return i_fused ? v | 64'd2 : v | 64'd1;
      18: return v | 64'd40;
      19: return i_addr_valid ? v | 64'd41 : 64'd0;
      20: return i_is_store ? 64'(i_l1_hit) :
                 i_src_valid ? v | 64'd42 : 64'd0;
      21: return (!i_is_store && i_lat_valid) ? v | 64'd43 : 64'd0;
      22: return v | 64'd44;
      23: return i_tx_valid ? v | 64'd45 : 64'd0;
      default: return v | 64'(k + 14);
    endcase
  endfunction
  task automatic rec(input int b);
    int n;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_record_done !== 1'b1 && n < 3000);
    if (n >= 3000) failures++;
    for (int k = 0; k < 24; k++)
      chk("slot", ex(k), pesr_mem_model_i.word[b + k]);
    chk("words", 64'(b + 24), 64'(words));
    chk("last", 64'h0000_0001_0000_00B8 + 64'(b * 8), last);
    repeat (2) @(negedge i_clock);
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_rstn <= 1;
    rdc("cap", REG_CAP, CAP_VALUE);
    rdc("ctrl", REG_CTRL, CTRL_RST);
    rdc("unmapped", 8'h1C, 32'h0000_0000);
    bus(1, REG_CAP, 32'h0000_0000);
    rdc("cap ro", REG_CAP, CAP_VALUE);
    $display("test registers done");
    bus(1, REG_BASE_HI, 32'h0000_0001);
    bus(1, REG_MASK, 32'h0000_0003);
    bus(1, REG_CTRL, 32'h0000_000F);
    snap(16'hA5A5, 7'b1011111);
    i_slow <= 1;
    fire(8'h01, 0);
    chk("busy", 1, o_capture_busy);
    fire(8'h04, 0);
    rec(0);
    chk("irq", 1, o_irq);
    rdc("status", REG_STATUS, 32'h0000_0003);
    rdc("status clr", REG_STATUS, 32'h0000_0000);
    chk("irq clr", 0, o_irq);
    rdc("count", REG_COUNT, 32'h0000_0001);
    fire(8'hF0, 0);
    chk("busy hi", 0, o_capture_busy);
    $display("test store record done");
    bus(1, REG_MASK, 32'h0000_0000);
    bus(1, REG_CTRL, 32'h0000_0102);
    snap(16'h5A5A, 7'b0101011);
    i_slow <= 0;
    fire(8'h02, 0);
    chk("busy plain", 0, o_capture_busy);
    fire(8'h00, 1);
    chk("busy precise_distribution_retired", 1, o_capture_busy);
    rec(24);
    chk("irq mask", 0, o_irq);
    rdc("status2", REG_STATUS, 32'h0000_0001);
    rdc("count2", REG_COUNT, 32'h0000_0002);
    $display("test load record done");
    bus(1, REG_CTRL, 32'h0000_0008);
    snap(16'h3C3C, 7'b0000000);
    fire(8'h08, 0);
    chk("busy three", 1, o_capture_busy);
    rec(48);
    rdc("count3", REG_COUNT, 32'h0000_0003);
    rdc("base hi", REG_BASE_HI, 32'h0000_0001);
    bus(1, REG_BASE_LO, 32'h0000_0100);
    rdc("base lo", REG_BASE_LO, 32'h0000_0100);
    rdc("count rst", REG_COUNT, 32'h0000_0000);
    rdc("mask", REG_MASK, 32'h0000_0000);
    $display("test sparse record done");
    close_out();
  end
endmodule
`default_nettype wire
